//--- include/plc_counter_pkg.sv
// What this block does
// - Counters numbered 0 to 31; a number used by a timer is not a counter.
// - High-speed mode keeps counters 0 to 15 only; adding counters 2 to 15.
// - Each preset is 0 to 9999, from a constant or a data register.
// - Data register preset above 9999 lights error lamp and sets error relay.
// - Preset registers 0 to 99 in standard mode, 0 to 31 in high-speed.
// - Dual-pulse counter inputs are preset, up pulse, down pulse, then preset.
// - Preset input loads count with preset; user asserts it before first use.
// - Reversible counter never counts while its preset input is held.
// - Up and down pulses in the same scan leave the count unchanged.
// - From the first clock after reset, reversible counter output is on exactly while the count is zero.
// - Reversible count wraps from zero to 9999 on a down count.
// - Reversible count wraps from 9999 to zero on an up count.
// - Counts are held through power loss and restored unchanged.
// - A preset change while running takes effect at once.
// - Direction counter inputs are preset, pulse, direction, then preset.
// - Direction counter counts up while direction input is on.
// - Direction counter counts down while direction input is off.
// - Thirty adding counters in standard mode, fourteen in high-speed mode.
// - Adding counter inputs are reset, pulse, number 2 to 31, preset.
// - Adding counter counts rising pulse edges while reset is off.
// - Adding output turns on at preset and stays on until reset or a preset above the count.
// - Reset clears the adding count; pulses are ignored during reset.
// - Counting resumes one scan after reset falls; reset beats pulses.
package plc_counter_pkg;
    localparam int CW = 14;
    localparam int DW = 16;
    localparam int IDXW = 7;
    localparam int N_COUNTERS = 32;
    localparam int N_COUNTERS_HS = 16;
    localparam int N_DREG_STD = 100;
    localparam int N_DREG_HS = 32;
    localparam int DUAL_IDX = 0;
    localparam int DIR_IDX = 1;
    localparam logic [CW-1:0] COUNT_MAX = 14'h270f;
    localparam logic [DW-1:0] PRESET_LIMIT = 16'h270f;
    localparam logic [CW-1:0] COUNT_ZERO = 14'h0000;
    localparam logic [CW-1:0] COUNT_STEP = 14'h0001;
    localparam logic [DW-1:0] DREG_RESET = 16'h0000;
endpackage : plc_counter_pkg

//--- hdl/updown_cell.sv
`timescale 1ns/1ps
module updown_cell #(
    parameter bit DUAL = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scan,
    input wire logic load_in,
    input wire logic pulse_in,
    input wire logic aux_in,
    input wire logic [plc_counter_pkg::CW-1:0] preset,
    output logic [plc_counter_pkg::CW-1:0] count_value,
    output logic zero_out
);
    typedef struct packed {
        logic [plc_counter_pkg::CW-1:0] count;
        logic prev_pulse;
        logic prev_aux;
        logic zero;
    } updown_state_s;
    updown_state_s st_q, st_d;
    logic pulse_rise, aux_rise, up_ev, dn_ev;

    // Edge events against last scan's levels
    always_comb begin
        pulse_rise = pulse_in & ~st_q.prev_pulse;
        aux_rise = aux_in & ~st_q.prev_aux;
        if (DUAL) begin
            up_ev = pulse_rise & ~aux_rise;
            dn_ev = aux_rise & ~pulse_rise;
        end else begin
            up_ev = pulse_rise & aux_in;
            dn_ev = pulse_rise & ~aux_in;
        end
    end

    // Next state: load beats counting, wrap at both ends
    always_comb begin
        st_d = st_q;
        if (scan) begin
            st_d.prev_pulse = pulse_in;
            st_d.prev_aux = aux_in;
            if (load_in) begin
                st_d.count = preset;
            end else if (up_ev) begin
                st_d.count = (st_q.count == plc_counter_pkg::COUNT_MAX) ?
                    plc_counter_pkg::COUNT_ZERO :
                    st_q.count + plc_counter_pkg::COUNT_STEP;
            end else if (dn_ev) begin
                st_d.count = (st_q.count == plc_counter_pkg::COUNT_ZERO) ?
                    plc_counter_pkg::COUNT_MAX :
                    st_q.count - plc_counter_pkg::COUNT_STEP;
            end
        end
        st_d.zero = (st_d.count == plc_counter_pkg::COUNT_ZERO);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_value = st_q.count;
    assign zero_out = st_q.zero;

    property p_load;
        @(posedge ref_clk) disable iff (rst)
        scan && load_in |=> st_q.count == $past(preset);
    endproperty
    a_load: assert property (p_load)
        else $error("preset load missed");

    property p_wrap_down;
        @(posedge ref_clk) disable iff (rst)
        scan && !load_in && dn_ev && st_q.count == 14'h0000
            |=> st_q.count == 14'h270f;
    endproperty
    a_wrap_down: assert property (p_wrap_down)
        else $error("down wrap wrong");

    property p_wrap_up;
        @(posedge ref_clk) disable iff (rst)
        scan && !load_in && up_ev && st_q.count == 14'h270f
            |=> st_q.count == 14'h0000;
    endproperty
    a_wrap_up: assert property (p_wrap_up)
        else $error("up wrap wrong");

    property p_zero;
        @(posedge ref_clk) disable iff (rst)
        !rst |=> zero_out == (count_value == 14'h0000);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero output wrong");
endmodule : updown_cell

//--- hdl/adding_cell.sv
`timescale 1ns/1ps
module adding_cell (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scan,
    input wire logic reset_in,
    input wire logic pulse_in,
    input wire logic [plc_counter_pkg::CW-1:0] preset,
    output logic [plc_counter_pkg::CW-1:0] count_value,
    output logic done_out
);
    typedef struct packed {
        logic [plc_counter_pkg::CW-1:0] count;
        logic prev_pulse;
        logic prev_reset;
        logic done;
    } adding_state_s;
    adding_state_s st_q, st_d;
    logic step;

    // Rising edge counted only when reset was off last scan too
    assign step = pulse_in & ~st_q.prev_pulse & ~st_q.prev_reset;

    // Next state; count saturates at the top of the range
    always_comb begin
        st_d = st_q;
        if (scan) begin
            st_d.prev_pulse = pulse_in;
            st_d.prev_reset = reset_in;
            if (reset_in) begin
                st_d.count = plc_counter_pkg::COUNT_ZERO;
            end else if (step &&
                st_q.count != plc_counter_pkg::COUNT_MAX) begin
                st_d.count = st_q.count + plc_counter_pkg::COUNT_STEP;
            end
        end
        // Live compare so a new preset acts at once
        st_d.done = ~st_d.prev_reset && (st_d.count >= preset);
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_value = st_q.count;
    assign done_out = st_q.done;

    property p_reset_clear;
        @(posedge ref_clk) disable iff (rst)
        scan && reset_in |=> count_value == 14'h0000 && !done_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset did not clear");

    property p_resume;
        @(posedge ref_clk) disable iff (rst)
        scan && !reset_in && st_q.prev_reset |=> $stable(count_value);
    endproperty
    a_resume: assert property (p_resume)
        else $error("counted in scan after reset");

    property p_step;
        @(posedge ref_clk) disable iff (rst)
        scan && !reset_in && step && count_value < 14'h270f
            |=> count_value == $past(count_value) + 14'h0001;
    endproperty
    a_step: assert property (p_step)
        else $error("edge not counted");

    property p_done;
        @(posedge ref_clk) disable iff (rst)
        !rst && !scan && !st_q.prev_reset && count_value >= preset
            |=> done_out;
    endproperty
    a_done: assert property (p_done)
        else $error("output missing at preset");
endmodule : adding_cell

//--- hdl/plc_counter_bank.sv
`timescale 1ns/1ps
module plc_counter_bank #(
    parameter int N_DREG = plc_counter_pkg::N_DREG_STD,
    parameter int N_DREG_FAST = plc_counter_pkg::N_DREG_HS,
    parameter int N_FAST = plc_counter_pkg::N_COUNTERS_HS
) (
    input wire logic ref_clk,
    input wire logic rst,
    // Scan and mode control
    input wire logic scan_strobe,
    input wire logic power_ok,
    input wire logic high_speed_mode,
    input wire logic [plc_counter_pkg::N_COUNTERS-1:0] counter_enable,
    // Per-counter program inputs
    input wire logic [plc_counter_pkg::N_COUNTERS-1:0] ctrl_in,
    input wire logic [plc_counter_pkg::N_COUNTERS-1:0] pulse_in,
    input wire logic down_pulse_in,
    input wire logic direction_in,
    // Preset selection
    input wire logic [plc_counter_pkg::N_COUNTERS-1:0] preset_from_dreg,
    input wire logic [plc_counter_pkg::N_COUNTERS*plc_counter_pkg::CW-1:0]
        preset_const,
    input wire logic [plc_counter_pkg::N_COUNTERS*plc_counter_pkg::IDXW-1:0]
        preset_index,
    // Data register write and read port
    input wire logic dreg_we,
    input wire logic [plc_counter_pkg::IDXW-1:0] dreg_addr,
    input wire logic [plc_counter_pkg::DW-1:0] dreg_wdata,
    output logic [plc_counter_pkg::DW-1:0] dreg_rdata,
    // Error reporting
    input wire logic error_clear,
    output logic program_error_lamp,
    output logic execution_error_relay,
    // Counter results
    output logic [plc_counter_pkg::N_COUNTERS-1:0] counter_out,
    output logic [plc_counter_pkg::N_COUNTERS*plc_counter_pkg::CW-1:0]
        count_value
);
    localparam int N = plc_counter_pkg::N_COUNTERS;
    localparam int CW = plc_counter_pkg::CW;
    localparam int DW = plc_counter_pkg::DW;
    localparam int IW = plc_counter_pkg::IDXW;
    localparam logic [IW-1:0] DREG_TOP = IW'(N_DREG - 1);
    localparam logic [IW-1:0] DREG_TOP_FAST = IW'(N_DREG_FAST - 1);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (N_DREG < 1 || N_DREG > (1 << IW)) begin : g_bad_dreg
        $error("data register count out of range");
    end
    if (N_DREG_FAST < 1 || N_DREG_FAST > N_DREG) begin : g_bad_fast
        $error("fast data register count out of range");
    end
    if (N_FAST < 3 || N_FAST > N) begin : g_bad_fast_counters
        $error("fast counter count out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [N_DREG-1:0][DW-1:0] dreg;
        logic [DW-1:0] rdata;
        logic error;
    } bank_state_s;
    bank_state_s st_q, st_d;

    logic [N-1:0] active;
    logic [N-1:0] scan_en;
    logic [N-1:0] preset_bad;
    logic [N-1:0][CW-1:0] preset_eff;
    logic [N-1:0][CW-1:0] cell_count;
    logic any_bad;

    ////////////////////////////////////////////////////////////////////////
    // Counter availability per mode
    always_comb begin
        for (int k = 0; k < N; k++) begin
            active[k] = counter_enable[k]
                && (!high_speed_mode || k < N_FAST);
        end
    end

    // Scan evaluation, frozen while power is down
    assign scan_en = active & {N{scan_strobe & power_ok}};

    ////////////////////////////////////////////////////////////////////////
    // Preset selection and range check
    always_comb begin
        logic [IW-1:0] idx;
        logic [DW-1:0] word;
        logic idx_ok;
        idx = '0;
        word = '0;
        idx_ok = 1'b0;
        for (int k = 0; k < N; k++) begin
            idx = preset_index[k*IW +: IW];
            idx_ok = high_speed_mode ? (idx <= DREG_TOP_FAST)
                                     : (idx <= DREG_TOP);
            word = idx_ok ? st_q.dreg[idx] : plc_counter_pkg::PRESET_LIMIT;
            if (preset_from_dreg[k]) begin
                preset_bad[k] = !idx_ok
                    || (word > plc_counter_pkg::PRESET_LIMIT);
                preset_eff[k] = preset_bad[k] ? plc_counter_pkg::COUNT_MAX
                                              : word[CW-1:0];
            end else begin
                preset_bad[k] = 1'b0;
                preset_eff[k] = (preset_const[k*CW +: CW] >
                    plc_counter_pkg::COUNT_MAX) ? plc_counter_pkg::COUNT_MAX
                    : preset_const[k*CW +: CW];
            end
        end
    end

    // Only a counter being evaluated can raise the error
    assign any_bad = |(preset_bad & scan_en);

    ////////////////////////////////////////////////////////////////////////
    // Data registers, read data and error flag
    always_comb begin
        st_d = st_q;
        if (dreg_we && dreg_addr <= DREG_TOP) begin
            st_d.dreg[dreg_addr] = dreg_wdata; // preset changes act at once
        end
        st_d.rdata = (dreg_addr <= DREG_TOP) ? st_q.dreg[dreg_addr]
                                             : plc_counter_pkg::DREG_RESET;
        if (error_clear) begin
            st_d.error = 1'b0;
        end
        if (any_bad) begin
            st_d.error = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q.dreg <= '0;
            st_q.rdata <= plc_counter_pkg::DREG_RESET;
            st_q.error <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dreg_rdata = st_q.rdata;
    assign program_error_lamp = st_q.error;
    assign execution_error_relay = st_q.error;

    ////////////////////////////////////////////////////////////////////////
    // Counter cells
    for (genvar k = 0; k < N; k++) begin : g_counter
        if (k == plc_counter_pkg::DUAL_IDX) begin : g_dual
            updown_cell #(
                .DUAL(1'b1)
            ) dual_pulse_counter (
                .ref_clk(ref_clk),
                .rst(rst),
                .scan(scan_en[k]),
                .load_in(ctrl_in[k]),
                .pulse_in(pulse_in[k]),
                .aux_in(down_pulse_in),
                .preset(preset_eff[k]),
                .count_value(cell_count[k]),
                .zero_out(counter_out[k])
            );
        end else if (k == plc_counter_pkg::DIR_IDX) begin : g_dir
            updown_cell #(
                .DUAL(1'b0)
            ) direction_select_counter (
                .ref_clk(ref_clk),
                .rst(rst),
                .scan(scan_en[k]),
                .load_in(ctrl_in[k]),
                .pulse_in(pulse_in[k]),
                .aux_in(direction_in),
                .preset(preset_eff[k]),
                .count_value(cell_count[k]),
                .zero_out(counter_out[k])
            );
        end else begin : g_add
            adding_cell adding_counter (
                .ref_clk(ref_clk),
                .rst(rst),
                .scan(scan_en[k]),
                .reset_in(ctrl_in[k]),
                .pulse_in(pulse_in[k]),
                .preset(preset_eff[k]),
                .count_value(cell_count[k]),
                .done_out(counter_out[k])
            );
        end
        assign count_value[k*CW +: CW] = cell_count[k];
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_err_set;
        @(posedge ref_clk) disable iff (rst)
        any_bad |=> execution_error_relay && program_error_lamp;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("bad preset not flagged");

    property p_err_hold;
        @(posedge ref_clk) disable iff (rst)
        execution_error_relay && !error_clear |=> execution_error_relay;
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("error flag dropped");

    property p_fast_freeze;
        @(posedge ref_clk) disable iff (rst)
        high_speed_mode |=> $stable(cell_count[N-1]);
    endproperty
    a_fast_freeze: assert property (p_fast_freeze)
        else $error("counter above fast range moved");

    property p_power_hold;
        @(posedge ref_clk) disable iff (rst)
        !power_ok |=> $stable(count_value);
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("count moved during power loss");

    property p_scan_only;
        @(posedge ref_clk) disable iff (rst)
        !scan_strobe |=> $stable(count_value);
    endproperty
    a_scan_only: assert property (p_scan_only)
        else $error("count moved outside a scan");

    property p_dreg_range;
        @(posedge ref_clk) disable iff (rst)
        dreg_we && dreg_addr > DREG_TOP |=> $stable(st_q.dreg);
    endproperty
    a_dreg_range: assert property (p_dreg_range)
        else $error("write beyond data registers");

    property p_dreg_write;
        @(posedge ref_clk) disable iff (rst)
        dreg_we && dreg_addr <= DREG_TOP
            |=> st_q.dreg[$past(dreg_addr)] == $past(dreg_wdata);
    endproperty
    a_dreg_write: assert property (p_dreg_write)
        else $error("data register write lost");

    property p_rdata_out;
        @(posedge ref_clk) disable iff (rst)
        dreg_addr > DREG_TOP |=> dreg_rdata == 16'h0000;
    endproperty
    a_rdata_out: assert property (p_rdata_out)
        else $error("read beyond data registers not zero");

    property p_err_clear;
        @(posedge ref_clk) disable iff (rst)
        error_clear && !any_bad |=> !execution_error_relay;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error flag not cleared");

    property p_err_scan;
        @(posedge ref_clk) disable iff (rst)
        !scan_strobe && !execution_error_relay |=> !execution_error_relay;
    endproperty
    a_err_scan: assert property (p_err_scan)
        else $error("error raised outside a scan");

    ////////////////////////////////////////////////////////////////////////
    // Per-counter checks
    for (genvar k = 0; k < N; k++) begin : g_chk
        property p_idx_err;
            @(posedge ref_clk) disable iff (rst)
            scan_en[k] && preset_from_dreg[k] && (high_speed_mode
                ? preset_index[k*IW +: IW] > DREG_TOP_FAST
                : preset_index[k*IW +: IW] > DREG_TOP)
                |=> execution_error_relay;
        endproperty
        a_idx_err: assert property (p_idx_err)
            else $error("bad preset index not flagged");

        property p_idle_hold;
            @(posedge ref_clk) disable iff (rst)
            !active[k] |=> $stable(count_value[k*CW +: CW]);
        endproperty
        a_idle_hold: assert property (p_idle_hold)
            else $error("unavailable counter moved");

        property p_in_range;
            @(posedge ref_clk) disable iff (rst)
            count_value[k*CW +: CW] <= 14'h270f;
        endproperty
        a_in_range: assert property (p_in_range)
            else $error("count above top of range");

        property p_const_preset;
            @(posedge ref_clk) disable iff (rst)
            !preset_from_dreg[k] && preset_const[k*CW +: CW] <= 14'h270f
                |-> preset_eff[k] == preset_const[k*CW +: CW];
        endproperty
        a_const_preset: assert property (p_const_preset)
            else $error("constant preset not used");
    end
endmodule : plc_counter_bank

//--- tb/scan_source.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Program side: issues one scan strobe for each program pass
module scan_source (
    input wire logic ref_clk,
    output logic scan_strobe,
    output logic [plc_counter_pkg::N_COUNTERS-1:0] counter_enable
);
    // Each number is given to one counter only, none to a timer
    initial counter_enable = 32'hffffffff;
    initial scan_strobe = 1'b0;

    // One pass; results are settled one cycle after the taking edge
    task automatic do_scan();
        @(posedge ref_clk);
        scan_strobe <= 1'b1;
        @(posedge ref_clk);
        scan_strobe <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : do_scan
endmodule : scan_source

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int W = plc_counter_pkg::CW;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic scan_strobe, power_ok = 1'b1, high_speed_mode = 1'b0;
    logic [31:0] counter_enable, ctrl_in = 32'h0, pulse_in = 32'h0;
    logic down_pulse_in = 1'b0, direction_in = 1'b0;
    logic [31:0] preset_from_dreg = 32'h0;
    logic [32*W-1:0] preset_const = '0;
    logic [32*7-1:0] preset_index = '0;
    logic dreg_we = 1'b0, error_clear = 1'b0;
    logic [6:0] dreg_addr = 7'h00;
    logic [15:0] dreg_wdata = 16'h0000, dreg_rdata;
    logic program_error_lamp, execution_error_relay;
    logic [31:0] counter_out;
    logic [32*W-1:0] count_value;
    int error_cnt = 0, n_compared = 0, cycles = 0;

    // Clock and hang guard
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    scan_source prog (.ref_clk(ref_clk), .scan_strobe(scan_strobe),
        .counter_enable(counter_enable));

    plc_counter_bank dut (.ref_clk(ref_clk), .rst(rst),
        .scan_strobe(scan_strobe), .power_ok(power_ok),
        .high_speed_mode(high_speed_mode), .counter_enable(counter_enable),
        .ctrl_in(ctrl_in), .pulse_in(pulse_in),
        .down_pulse_in(down_pulse_in), .direction_in(direction_in),
        .preset_from_dreg(preset_from_dreg), .preset_const(preset_const),
        .preset_index(preset_index), .dreg_we(dreg_we),
        .dreg_addr(dreg_addr), .dreg_wdata(dreg_wdata),
        .dreg_rdata(dreg_rdata), .error_clear(error_clear),
        .program_error_lamp(program_error_lamp),
        .execution_error_relay(execution_error_relay),
        .counter_out(counter_out), .count_value(count_value));

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks
    task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(string what, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    // Count of counter k, widened to the compare width
    task automatic chk_cnt(int k, logic [15:0] exp);
        chk_val($sformatf("count %0d", k), exp,
            {2'b00, count_value[k*W +: W]});
    endtask : chk_cnt

    ////////////////////////////////////////////////////////////////////////
    // Program-side helpers
    task automatic set_pre(int k, logic [W-1:0] v);
        @(posedge ref_clk);
        preset_const[k*W +: W] <= v;
    endtask : set_pre

    task automatic set_ctrl(int k, logic v);
        @(posedge ref_clk);
        ctrl_in[k] <= v;
    endtask : set_ctrl

    // Rising edge in one scan, falling edge in the next
    task automatic pulse(int k);
        @(posedge ref_clk);
        pulse_in[k] <= 1'b1;
        prog.do_scan();
        @(posedge ref_clk);
        pulse_in[k] <= 1'b0;
        prog.do_scan();
    endtask : pulse

    task automatic dreg_write(logic [6:0] a, logic [15:0] d);
        @(posedge ref_clk);
        dreg_we <= 1'b1;
        dreg_addr <= a;
        dreg_wdata <= d;
        @(posedge ref_clk);
        dreg_we <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : dreg_write

    task automatic chk_err(logic exp);
        chk_bit("error lamp", exp, program_error_lamp);
        chk_bit("error relay", exp, execution_error_relay);
    endtask : chk_err

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_cnt(0, 16'h0000);
        chk_bit("zero out 1", 1'b1, counter_out[1]);
        chk_err(1'b0);
        $display("test reset done");

        // Dual-pulse counter
        set_pre(0, 14'h01f4);
        set_ctrl(0, 1'b1);
        prog.do_scan();
        chk_cnt(0, 16'h01f4);
        pulse(0);
        chk_cnt(0, 16'h01f4);
        set_ctrl(0, 1'b0);
        pulse(0);
        chk_cnt(0, 16'h01f5);
        @(posedge ref_clk);
        down_pulse_in <= 1'b1;
        pulse(0);
        chk_cnt(0, 16'h01f5);
        @(posedge ref_clk);
        down_pulse_in <= 1'b0;
        prog.do_scan();
        @(posedge ref_clk);
        down_pulse_in <= 1'b1;
        prog.do_scan();
        chk_cnt(0, 16'h01f4);
        set_pre(0, 14'h0000);
        set_ctrl(0, 1'b1);
        down_pulse_in <= 1'b0;
        prog.do_scan();
        chk_bit("zero out 0", 1'b1, counter_out[0]);
        set_ctrl(0, 1'b0);
        @(posedge ref_clk);
        down_pulse_in <= 1'b1;
        prog.do_scan();
        chk_cnt(0, 16'h270f);
        chk_bit("zero out 0", 1'b0, counter_out[0]);
        down_pulse_in <= 1'b0;
        pulse(0);
        chk_cnt(0, 16'h0000);
        $display("test dual pulse done");

        // Direction-select counter
        set_pre(1, 14'h270f);
        set_ctrl(1, 1'b1);
        prog.do_scan();
        set_ctrl(1, 1'b0);
        direction_in <= 1'b1;
        pulse(1);
        chk_cnt(1, 16'h0000);
        direction_in <= 1'b0;
        pulse(1);
        chk_cnt(1, 16'h270f);
        $display("test direction done");

        // Adding counter: reset, release, count, preset change
        set_pre(2, 14'h0003);
        set_ctrl(2, 1'b1);
        prog.do_scan();
        pulse(2);
        chk_cnt(2, 16'h0000);
        chk_bit("add out 2", 1'b0, counter_out[2]);
        set_ctrl(2, 1'b0);
        pulse_in[2] <= 1'b1;
        prog.do_scan();
        chk_cnt(2, 16'h0000);
        pulse_in[2] <= 1'b0;
        prog.do_scan();
        pulse(2);
        pulse(2);
        chk_cnt(2, 16'h0002);
        chk_bit("add out 2", 1'b0, counter_out[2]);
        set_pre(2, 14'h0002);
        repeat (3) @(posedge ref_clk);
        #1;
        chk_bit("add out 2", 1'b1, counter_out[2]);
        pulse(2);
        chk_bit("add out 2", 1'b1, counter_out[2]);
        power_ok <= 1'b0;
        pulse(2);
        chk_cnt(2, 16'h0003);
        power_ok <= 1'b1;
        $display("test adding done");

        // Data register presets and error flag
        dreg_write(7'h05, 16'h2710);
        chk_val("dreg read", 16'h2710, dreg_rdata);
        preset_index[3*7 +: 7] <= 7'h05;
        preset_from_dreg[3] <= 1'b1;
        prog.do_scan();
        chk_err(1'b1);
        preset_from_dreg[3] <= 1'b0;
        error_clear <= 1'b1;
        @(posedge ref_clk);
        error_clear <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_err(1'b0);
        dreg_write(7'h28, 16'h0005);
        preset_index[3*7 +: 7] <= 7'h28;
        preset_from_dreg[3] <= 1'b1;
        prog.do_scan();
        chk_err(1'b0);
        high_speed_mode <= 1'b1;
        pulse(20);
        chk_cnt(20, 16'h0000);
        chk_err(1'b1);
        high_speed_mode <= 1'b0;
        pulse(20);
        chk_cnt(20, 16'h0001);
        dreg_write(7'h64, 16'h1234);
        chk_val("dreg read", 16'h0000, dreg_rdata);
        $display("test data register done");
        end_sim();
    end
endmodule : tb_top
